// ---- ddt_cmd_timing.sv ----
// device-side command timing: bank lockout, refresh, termination
// assumes link pins are synchronous to linkClk; ref_clk side reads status only
`timescale 1ns/1ps
`default_nettype none
`include "ddt_params.svh"
module ddt_cmd_timing (
    input  wire logic                ref_clk,
    input  wire logic                rstn,
    input  wire logic                linkClk,
    input  wire logic                ckeIn,
    input  wire logic                odtIn,
    input  wire ddt_pkg::ddt_pins_s  cmdPins,
    output logic                     prechargePulse,
    output logic [`DDT_BANK_W-1:0]   prechargeBank,
    output ddt_pkg::ddt_rtt_e        rttSel,
    output logic                     rttPartial,
    output logic                     rttFull,
    output logic [`DDT_NUM_BANKS-1:0] bankOpen,
    output logic [`DDT_REF_W-1:0]    refreshCount,
    output logic                     termOnStatus
);
    // ==========================================================
    // link reset: async assert, release aligned to linkClk
    logic [1:0] linkRst_q;
    logic       linkRstn;
    always_ff @(posedge linkClk or negedge rstn) begin
        if (!rstn) begin
            linkRst_q <= 2'h0;
        end else begin
            linkRst_q <= {linkRst_q[0], 1'b1};
        end
    end
    assign linkRstn = linkRst_q[1];

    // ==========================================================
    // pin registers (same domain as the controller's clock)
    logic               cke_q;
    logic               odt_q;
    ddt_pkg::ddt_pins_s pins_q;
    ddt_pkg::ddt_cmd_e  cmd;
    always_ff @(posedge linkClk or negedge linkRstn) begin
        if (!linkRstn) begin
            cke_q  <= 1'b0;
            odt_q  <= 1'b0;
            pins_q <= '{csN: 1'b1, rasN: 1'b1, casN: 1'b1, weN: 1'b1, default: '0};
        end else begin
            cke_q  <= ckeIn;
            odt_q  <= odtIn;
            pins_q <= cmdPins;
        end
    end
    // commands only count while clock enable is registered high
    assign cmd = cke_q ? ddt_pkg::decodeCmd(pins_q) : ddt_pkg::CMD_NOP;

    // ==========================================================
    // bank state
    logic [`DDT_NUM_BANKS-1:0] open_q, open_d, apPend_q, apPend_d;
    logic [`DDT_CNT_W-1:0]     ras_q [`DDT_NUM_BANKS];
    logic [`DDT_CNT_W-1:0]     ras_d [`DDT_NUM_BANKS];
    logic                      pre_d;
    logic [`DDT_BANK_W-1:0]    preBank_d;
    logic [`DDT_REF_W-1:0]     ref_q, ref_d;
    ddt_pkg::ddt_rtt_e         rtt_q, rtt_d;
    logic                      hitBank, apBit;

    always_comb begin
        open_d    = open_q;
        apPend_d  = apPend_q;
        pre_d     = 1'b0;
        preBank_d = '0;
        ref_d     = ref_q;
        rtt_d     = rtt_q;
        apBit     = pins_q.addr[`DDT_AP_BIT];
        for (int b = 0; b < `DDT_NUM_BANKS; b++) begin
            hitBank  = (pins_q.bank == b[`DDT_BANK_W-1:0]);
            ras_d[b] = (ras_q[b] != `DDT_CNT_ZERO) ? ras_q[b] - `DDT_CNT_ONE : ras_q[b];
            // pending auto precharge waits out the row-active count
            if (apPend_q[b] && ras_q[b] == `DDT_CNT_ZERO) begin
                open_d[b]   = 1'b0;
                apPend_d[b] = 1'b0;
                pre_d       = 1'b1;
                preBank_d   = b[`DDT_BANK_W-1:0];
            end
            unique case (cmd)
                ddt_pkg::CMD_ACT: if (hitBank) begin
                    open_d[b] = 1'b1;
                    ras_d[b]  = `DDT_TRAS_CK - `DDT_CNT_ONE;
                end
                // taken even while the row-active count still runs
                ddt_pkg::CMD_RD, ddt_pkg::CMD_WR: if (hitBank && apBit && open_q[b]) begin
                    apPend_d[b] = 1'b1;
                end
                ddt_pkg::CMD_PRE: if (hitBank || apBit) begin
                    open_d[b]   = 1'b0;
                    apPend_d[b] = 1'b0;
                end
                default: ;
            endcase
        end
        // no upper bound on refresh bursts: every edge may count one
        if (cmd == ddt_pkg::CMD_REF) begin
            ref_d = ref_q + `DDT_REF_ONE;
        end
        if (cmd == ddt_pkg::CMD_MRS && pins_q.bank == `DDT_BA_EMR) begin
            rtt_d = ddt_pkg::ddt_rtt_e'({pins_q.addr[`DDT_RTT_HI_BIT], pins_q.addr[`DDT_RTT_LO_BIT]});
        end
    end

    logic [`DDT_REF_W-1:0] refGray_q;
    always_ff @(posedge linkClk or negedge linkRstn) begin
        if (!linkRstn) begin
            open_q         <= '0;
            apPend_q       <= '0;
            ras_q          <= '{default: `DDT_CNT_ZERO};
            prechargePulse <= 1'b0;
            prechargeBank  <= '0;
            ref_q          <= '0;
            refGray_q      <= '0;
            rtt_q          <= ddt_pkg::RTT_OFF;
        end else begin
            open_q         <= open_d;
            apPend_q       <= apPend_d;
            ras_q          <= ras_d;
            prechargePulse <= pre_d;
            prechargeBank  <= preBank_d;
            ref_q          <= ref_d;
            refGray_q      <= ref_d ^ (ref_d >> 1);
            rtt_q          <= rtt_d;
        end
    end
    assign rttSel = rtt_q;

    // ==========================================================
    // termination timing: two rising edges then a falling edge gives 2.5 clocks
    logic odt2_q, odt3_q, full_q;
    always_ff @(posedge linkClk or negedge linkRstn) begin
        if (!linkRstn) begin
            odt2_q <= 1'b0;
            odt3_q <= 1'b0;
        end else begin
            odt2_q <= odt_q;
            odt3_q <= odt2_q;
        end
    end
    // falling-edge stage adds the half clock; it tracks real duty cycle
    always_ff @(negedge linkClk or negedge linkRstn) begin
        if (!linkRstn) begin
            full_q <= 1'b0;
        end else begin
            full_q <= odt3_q;
        end
    end
    assign rttPartial = odt3_q;
    assign rttFull    = full_q;

    // ==========================================================
    // status crossing into ref_clk: levels and gray count only
    logic [`DDT_REF_W-1:0] refGraySync;
    logic                  termSync;
    ddt_sync #(.WIDTH(`DDT_NUM_BANKS)) u_bankSync (
        .clk  (ref_clk),
        .rstn (rstn),
        .din  (open_q),
        .dout (bankOpen)
    );
    ddt_sync #(.WIDTH(`DDT_REF_W + 1)) u_refSync (
        .clk  (ref_clk),
        .rstn (rstn),
        .din  ({full_q, refGray_q}),
        .dout ({termSync, refGraySync})
    );
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            refreshCount <= '0;
            termOnStatus <= 1'b0;
        end else begin
            refreshCount <= ddt_pkg::grayToBin(refGraySync);
            termOnStatus <= termSync;
        end
    end

    // ==========================================================
    // checks on the link side
    sequence apEarly_s;
        cmd == ddt_pkg::CMD_RD && apBit && open_q[pins_q.bank] && ras_q[pins_q.bank] > `DDT_CNT_ONE;
    endsequence
    sequence odtHeldLow_s;
        $fell(odt_q) ##1 !odt_q ##1 !odt_q;
    endsequence
    sequence odtHeldHigh_s;
        $rose(odt_q) ##1 odt_q ##1 odt_q;
    endsequence

    ap_accept_a: assert property (@(posedge linkClk) disable iff (!linkRstn)
        apEarly_s |=> apPend_q[$past(pins_q.bank)] && open_q[$past(pins_q.bank)])
        else $error("early auto precharge not accepted");
    ap_lockout_a: assert property (@(posedge linkClk) disable iff (!linkRstn)
        apEarly_s |=> !prechargePulse ##1 !prechargePulse)
        else $error("internal precharge before row-active time");
    ap_fire_a: assert property (@(posedge linkClk) disable iff (!linkRstn)
        (apPend_q[0] && ras_q[0] == `DDT_CNT_ZERO) |=> prechargePulse && !open_q[0])
        else $error("due precharge not performed");
    ref_burst_a: assert property (@(posedge linkClk) disable iff (!linkRstn)
        (cmd == ddt_pkg::CMD_REF) [*2] |=> ref_q == $past(ref_q, 2) + 13'h0002)
        else $error("back-to-back refresh lost");
    rtt_decode_a: assert property (@(posedge linkClk) disable iff (!linkRstn)
        (cmd == ddt_pkg::CMD_MRS && pins_q.bank == `DDT_BA_EMR
            && pins_q.addr[`DDT_RTT_HI_BIT] && !pins_q.addr[`DDT_RTT_LO_BIT])
        |=> rttSel == ddt_pkg::RTT_150)
        else $error("termination code decoded wrongly");
    term_off_a: assert property (@(posedge linkClk) disable iff (!linkRstn)
        odtHeldLow_s |-> !rttFull && !rttPartial)
        else $error("termination not off after 2.5 clocks");
    term_hold_a: assert property (@(posedge linkClk) disable iff (!linkRstn)
        ($fell(odt_q) && rttFull) |=> rttFull)
        else $error("termination dropped early");
    term_on_a: assert property (@(posedge linkClk) disable iff (!linkRstn)
        odtHeldHigh_s |-> rttPartial && rttFull)
        else $error("termination not fully on");
endmodule // ddt_cmd_timing
`default_nettype wire

// ---- ddt_params.svh ----
// constants for the dram command-timing block
// assumes a 4-bank part with a 14-bit row/column address bus
`ifndef DDT_PARAMS_SVH
`define DDT_PARAMS_SVH
`define DDT_NUM_BANKS   4
`define DDT_BANK_W      2
`define DDT_ADDR_W      14
`define DDT_CNT_W       4
`define DDT_TRAS_CK     4'h8
`define DDT_CNT_ZERO    4'h0
`define DDT_CNT_ONE     4'h1
`define DDT_REF_W       13
`define DDT_REF_ONE     13'h0001
`define DDT_AP_BIT      10
`define DDT_RTT_HI_BIT  6
`define DDT_RTT_LO_BIT  2
`define DDT_BA_MR       2'h0
`define DDT_BA_EMR      2'h1
`endif

// ---- ddt_pkg.sv ----
// types shared by the dram command-timing block
// assumes ddt_params.svh is on the include path
`include "ddt_params.svh"
package ddt_pkg;
    typedef enum logic [2:0] {
        CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS
    } ddt_cmd_e;
    // order gives the {a6,a2} code: off, 75, 150, 50 ohm
    typedef enum logic [1:0] {RTT_OFF, RTT_75, RTT_150, RTT_50} ddt_rtt_e;
    typedef struct packed {
        logic                      csN;
        logic                      rasN;
        logic                      casN;
        logic                      weN;
        logic [`DDT_BANK_W-1:0]    bank;
        logic [`DDT_ADDR_W-1:0]    addr;
    } ddt_pins_s;

    function automatic ddt_cmd_e decodeCmd(input ddt_pins_s p);
        ddt_cmd_e c;
        c = CMD_NOP;
        if (!p.csN) begin
            unique case ({p.rasN, p.casN, p.weN})
                3'h3: c = CMD_ACT;
                3'h5: c = CMD_RD;
                3'h4: c = CMD_WR;
                3'h2: c = CMD_PRE;
                3'h1: c = CMD_REF;
                3'h0: c = CMD_MRS;
                default: c = CMD_NOP;
            endcase
        end
        return c;
    endfunction

    function automatic logic [`DDT_REF_W-1:0] grayToBin(input logic [`DDT_REF_W-1:0] g);
        logic [`DDT_REF_W-1:0] b;
        b = g;
        for (int i = `DDT_REF_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction
endpackage

// ---- ddt_sync.sv ----
// two-flop level synchroniser for a word of quasi-static or gray-coded bits
// assumes each bit, or the word as a gray code, changes one bit at a time
`timescale 1ns/1ps
`default_nettype none
module ddt_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            dout   <= '0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule // ddt_sync
`default_nettype wire

// ---- ddt_ctrl_model.sv ----
// controller-side model: drives command, clock enable and termination pins
// assumes the bench runs linkClk; every pin changes just after its rising edge
`timescale 1ns/1ps
`default_nettype none
module ddt_ctrl_model (
    input  wire logic               linkClk,
    output var  logic               ckeOut,
    output var  logic               odtOut,
    output var  ddt_pkg::ddt_pins_s pins
);
    // ==========================================
    // idle levels
    initial begin
        ckeOut = 1'b0;
        odtOut = 1'b0;
        pins   = {1'b1, 3'h7, 2'h0, 14'h0000};
    end

    // ==========================================
    // pin tasks
    // command held n edges, so n > 1 gives back-to-back repeats
    task automatic send(input logic [2:0] rcw, input logic [1:0] bk, input logic [13:0] ad, input int n);
        @(posedge linkClk);
        pins <= {1'b0, rcw, bk, ad};
        repeat (n) @(posedge linkClk);
        // deselected: other lines flip so a stale value never looks valid
        pins <= {1'b1, ~rcw, ~bk, ~ad};
    endtask

    task automatic setCke(input logic v);
        @(posedge linkClk);
        ckeOut <= v;
        repeat (3) @(posedge linkClk);
    endtask

    task automatic setOdt(input logic v);
        @(posedge linkClk);
        odtOut <= v;
    endtask
endmodule // ddt_ctrl_model
`default_nettype wire

// ---- ddt_cmd_timing_test.sv ----
// self-checking bench for the command-timing block
// assumes ddt_pkg is compiled first; the controller model drives all link pins
`timescale 1ns/1ps
`default_nettype none
module ddt_cmd_timing_test;
    typedef struct packed {
        logic [13:0]       addr;
        ddt_pkg::ddt_rtt_e rtt;
    } ddt_row_s;

    logic               ref_clk;
    logic               rstn;
    logic               linkClk;
    logic               ckeIn;
    logic               odtIn;
    ddt_pkg::ddt_pins_s cmdPins;
    logic               prechargePulse;
    logic [1:0]         prechargeBank;
    ddt_pkg::ddt_rtt_e  rttSel;
    logic               rttPartial;
    logic               rttFull;
    logic [3:0]         bankOpen;
    logic [12:0]        refreshCount;
    logic               termOnStatus;
    int                 err_count;
    int                 num_checks;
    int                 n;
    ddt_row_s           rows [4];

    ddt_ctrl_model i_ddt_ctrl_model (.linkClk(linkClk), .ckeOut(ckeIn), .odtOut(odtIn), .pins(cmdPins));
    ddt_cmd_timing i_ddt_cmd_timing (.ref_clk(ref_clk), .rstn(rstn), .linkClk(linkClk), .ckeIn(ckeIn),
        .odtIn(odtIn), .cmdPins(cmdPins), .prechargePulse(prechargePulse), .prechargeBank(prechargeBank),
        .rttSel(rttSel), .rttPartial(rttPartial), .rttFull(rttFull), .bankOpen(bankOpen),
        .refreshCount(refreshCount), .termOnStatus(termOnStatus));

    // ==========================================
    // clocks: link clock period chosen so rising edges never line up by design
    initial ref_clk = 1'b0;
    always #25 ref_clk = ~ref_clk;
    // 80 ns period against 50 ns: rising edges of the two never coincide
    initial linkClk = 1'b0;
    always #40 linkClk = ~linkClk;

    // ==========================================
    // helpers
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic waitPulse(output int cnt);
        cnt = 0;
        do begin
            @(posedge linkClk);
            #1;
            cnt++;
        end while (prechargePulse !== 1'b1 && cnt < 20);
        if (cnt >= 20) begin
            err_count++;
            final_report();
        end
    endtask

    // on and off both take two clocks to start, half a clock more to finish
    task automatic odtStep(input logic v);
        i_ddt_ctrl_model.setOdt(v);
        repeat (2) @(posedge linkClk);
        #1;
        chk(rttPartial, !v);
        @(posedge linkClk);
        #1;
        chk(rttPartial, v);
        chk(rttFull, !v);
        @(negedge linkClk);
        #1;
        chk(rttFull, v);
        repeat (4) @(posedge ref_clk);
        chk(termOnStatus, v);
    endtask

    // ==========================================
    // main sequence
    initial begin
        rstn = 1'b0;
        err_count = 0;
        num_checks = 0;
        rows = '{'{14'h0000, ddt_pkg::RTT_OFF}, '{14'h0004, ddt_pkg::RTT_75},
                 '{14'h0040, ddt_pkg::RTT_150}, '{14'h0044, ddt_pkg::RTT_50}};
        repeat (12) @(posedge ref_clk);
        chk(rttSel, ddt_pkg::RTT_OFF);
        chk(refreshCount, 16'h0000);
        rstn <= 1'b1;
        repeat (4) @(posedge linkClk);
        i_ddt_ctrl_model.setCke(1'b1);
        for (int i = 0; i < 4; i++) begin
            i_ddt_ctrl_model.send(3'h0, 2'h1, rows[i].addr, 1);
            repeat (3) @(posedge linkClk);
            chk(rttSel, rows[i].rtt);
        end
        // mode write to the other bank must leave termination alone
        i_ddt_ctrl_model.send(3'h0, 2'h0, 14'h0000, 1);
        repeat (3) @(posedge linkClk);
        chk(rttSel, ddt_pkg::RTT_50);
        // auto precharge right after activate: held off for row-active time
        i_ddt_ctrl_model.send(3'h3, 2'h0, 14'h0000, 1);
        i_ddt_ctrl_model.send(3'h5, 2'h0, 14'h0400, 1);
        waitPulse(n);
        chk({15'h0000, n >= 5 && n <= 8}, 16'h0001);
        chk(prechargeBank, 16'h0000);
        @(posedge linkClk);
        #1;
        chk(prechargePulse, 16'h0000);
        repeat (4) @(posedge ref_clk);
        chk(bankOpen, 16'h0000);
        // row-active time already met: write with precharge closes at once
        i_ddt_ctrl_model.send(3'h3, 2'h1, 14'h0000, 1);
        repeat (12) @(posedge linkClk);
        chk(bankOpen, 16'h0002);
        i_ddt_ctrl_model.send(3'h4, 2'h1, 14'h0400, 1);
        waitPulse(n);
        chk({15'h0000, n <= 3}, 16'h0001);
        chk(prechargeBank, 16'h0001);
        // refresh burst, then one refresh while clock enable is low
        i_ddt_ctrl_model.send(3'h1, 2'h0, 14'h0000, 5);
        repeat (3) @(posedge linkClk);
        repeat (4) @(posedge ref_clk);
        chk(refreshCount, 16'h0005);
        i_ddt_ctrl_model.setCke(1'b0);
        i_ddt_ctrl_model.send(3'h1, 2'h0, 14'h0000, 1);
        i_ddt_ctrl_model.setCke(1'b1);
        repeat (4) @(posedge ref_clk);
        chk(refreshCount, 16'h0005);
        odtStep(1'b1);
        odtStep(1'b0);
        final_report();
    end
endmodule // ddt_cmd_timing_test
`default_nettype wire
